// ===== ccb_pkg.sv
// shared constants, types and helpers of the control-input and bus-status block
package ccb_pkg;

   // ----------------------------------------------------------------
   // status codes, highest line first
   // ----------------------------------------------------------------
   localparam logic [2:0] CCB_ST_INTA    = 3'h0;
   localparam logic [2:0] CCB_ST_IO_RD   = 3'h1;
   localparam logic [2:0] CCB_ST_IO_WR   = 3'h2;
   localparam logic [2:0] CCB_ST_HALT    = 3'h3;
   localparam logic [2:0] CCB_ST_CODE    = 3'h4;
   localparam logic [2:0] CCB_ST_MEM_RD  = 3'h5;
   localparam logic [2:0] CCB_ST_MEM_WR  = 3'h6;
   localparam logic [2:0] CCB_ST_PASSIVE = 3'h7;

   // ----------------------------------------------------------------
   // interrupt, timing and mode strap constants
   // ----------------------------------------------------------------
   localparam logic [7:0] CCB_EDGE_INT_TYPE = 8'h02;
   localparam int CCB_VEC_ADDR_W = 20;
   localparam int CCB_VEC_SHIFT = 2;
   localparam int CCB_SYNC_STAGES = 2;
   localparam int CCB_RESET_MIN_CYCLES = 4;
   localparam logic CCB_STRAP_MAX_MODE = 1'b0;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CCB_IDLE,
      CCB_CLOCK_STATE_1,
      CCB_CLOCK_STATE_2,
      CCB_CLOCK_STATE_3,
      CCB_WAIT_STATE,
      CCB_CLOCK_STATE_4
   } ccb_clk_state_t;

   typedef struct packed {
      logic [2:0] value;
      logic [2:0] oe;
   } ccb_status_pins_t;

   typedef struct packed {
      ccb_clk_state_t state;
      logic [2:0] code;
      logic active;
      logic max_mode;
      logic strap_taken;
      logic rst_prev;
      logic nmi_prev;
      logic nmi_pending;
      logic nmi_take;
      logic core_hold;
      logic core_restart;
      logic req_ready;
      logic cycle_start;
      logic cycle_end;
      ccb_status_pins_t pins;
   } ccb_state_t;

   // vector table entry address of an interrupt type
   function automatic logic [CCB_VEC_ADDR_W-1:0] ccb_vector_addr(input logic [7:0] itype);
      logic [CCB_VEC_ADDR_W-1:0] a;
      a = {{(CCB_VEC_ADDR_W-8){1'b0}}, itype};
      return a << CCB_VEC_SHIFT;
   endfunction : ccb_vector_addr

endpackage : ccb_pkg

// ===== ccb_sync.sv
// two-flop synchroniser for asynchronous control inputs
`timescale 1ns/1ps
module ccb_sync #(
   parameter int W = 2
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   import ccb_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ccb_sync_state_t;

   ccb_sync_state_t st_r;
   ccb_sync_state_t st_nxt;

   always_comb begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;

endmodule : ccb_sync

// ===== ccb_core.sv
// control inputs (edge interrupt, reset, mode strap) and encoded bus status
//
// Contract
// - a rising edge on the edge interrupt input takes interrupt type 2
// - the service address is fetched from the vector table in memory
// - no software mask or enable flag blocks the edge interrupt
// - the edge interrupt is taken only when the current instruction completes
// - the edge interrupt input is synchronised before edge detection
// - asserted reset abandons the current instruction and bus cycle at once
// - execution restarts from the start-up state when reset falls
// - the reset input is synchronised before either transition acts
// - a grounded mode strap selects maximum mode, enabling status outputs
// - code driven in clock states 4, 1, 2; passive 111 in state 3 or wait
// - status leaving passive in clock state 4 marks the start of a bus cycle
// - status returning to passive in clock state 3 marks cycle end
// - status outputs float, reading as one, while the bus is granted
`timescale 1ns/1ps
module ccb_core (
   input wire logic clk,
   input wire logic resetn,
   input wire logic reset_pin,
   input wire logic nmi_pin,
   input wire logic bus_mode_strap,
   input wire logic ready,
   input wire logic bus_granted,
   input wire logic req_valid,
   input wire logic [2:0] req_code,
   input wire logic instr_done,
   output logic req_ready,
   output logic nmi_take,
   output logic [7:0] nmi_type,
   output logic [ccb_pkg::CCB_VEC_ADDR_W-1:0] nmi_vector,
   output logic core_hold_reset,
   output logic core_restart,
   output ccb_pkg::ccb_status_pins_t status_pins,
   output ccb_pkg::ccb_clk_state_t clock_state,
   output logic cycle_start,
   output logic cycle_end
);
   import ccb_pkg::*;

   // ----------------------------------------------------------------
   // synchronisers
   // ----------------------------------------------------------------
   logic [1:0] sync_q;
   logic rst_s;
   logic nmi_s;

   ccb_sync #(.W(2)) u_sync (
      .clk(clk),
      .resetn(resetn),
      .d({reset_pin, nmi_pin}),
      .q(sync_q)
   );

   assign rst_s = sync_q[1];
   assign nmi_s = sync_q[0];

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   ccb_state_t st_r;
   ccb_state_t st_nxt;
   logic take;
   logic nmi_edge;
   logic [2:0] drive_val;

   always_comb begin
      st_nxt = st_r;
      st_nxt.rst_prev = rst_s;
      st_nxt.nmi_prev = nmi_s;
      st_nxt.nmi_take = 1'b0;
      st_nxt.core_restart = 1'b0;
      st_nxt.cycle_start = 1'b0;
      st_nxt.cycle_end = 1'b0;
      take = 1'b0;
      drive_val = CCB_ST_PASSIVE;
      // strap is static; caught once after release
      if (!st_r.strap_taken) begin
         st_nxt.strap_taken = 1'b1;
         st_nxt.max_mode = (bus_mode_strap == CCB_STRAP_MAX_MODE);
      end
      // edge interrupt: no mask term exists on this path
      nmi_edge = nmi_s && !st_r.nmi_prev;
      if (st_r.nmi_pending && instr_done) begin
         st_nxt.nmi_take = 1'b1;
         st_nxt.nmi_pending = 1'b0;
      end
      if (nmi_edge) begin
         st_nxt.nmi_pending = 1'b1;
      end
      if (rst_s) begin
         // abort everything at once
         st_nxt.state = CCB_IDLE;
         st_nxt.active = 1'b0;
         st_nxt.code = CCB_ST_PASSIVE;
         st_nxt.nmi_pending = 1'b0;
         st_nxt.nmi_take = 1'b0;
         st_nxt.core_hold = 1'b1;
      end else begin
         st_nxt.core_hold = 1'b0;
         if (st_r.rst_prev) begin
            st_nxt.core_restart = 1'b1;
         end
         take = req_valid && st_r.req_ready && !bus_granted &&
                ((st_r.state == CCB_IDLE) || ready);
         case (st_r.state)
            CCB_IDLE: begin
               if (take) begin
                  st_nxt.state = CCB_CLOCK_STATE_4;
                  st_nxt.active = 1'b1;
                  st_nxt.code = req_code;
                  st_nxt.cycle_start = 1'b1;
               end
            end
            CCB_CLOCK_STATE_4: begin
               if (st_r.active) begin
                  st_nxt.state = CCB_CLOCK_STATE_1;
               end else begin
                  st_nxt.state = CCB_IDLE;
               end
            end
            CCB_CLOCK_STATE_1: begin
               st_nxt.state = CCB_CLOCK_STATE_2;
            end
            CCB_CLOCK_STATE_2: begin
               st_nxt.state = CCB_CLOCK_STATE_3;
               st_nxt.active = 1'b0;
               st_nxt.cycle_end = 1'b1;
            end
            CCB_CLOCK_STATE_3, CCB_WAIT_STATE: begin
               if (ready) begin
                  st_nxt.state = CCB_CLOCK_STATE_4;
                  st_nxt.active = take;
                  if (take) begin
                     st_nxt.code = req_code;
                     st_nxt.cycle_start = 1'b1;
                  end
               end else begin
                  st_nxt.state = CCB_WAIT_STATE;
               end
            end
            default: begin
               st_nxt.state = CCB_IDLE;
            end
         endcase
      end
      st_nxt.req_ready = !rst_s && !bus_granted &&
                         ((st_nxt.state == CCB_IDLE) || (st_nxt.state == CCB_CLOCK_STATE_3) ||
                          (st_nxt.state == CCB_WAIT_STATE));
      // status pins: code in clock states 4, 1, 2, passive otherwise
      if (st_nxt.active) begin
         drive_val = st_nxt.code;
      end
      st_nxt.pins.value = drive_val;
      if (st_nxt.max_mode && !bus_granted && st_nxt.strap_taken) begin
         st_nxt.pins.oe = 3'h7;
      end else begin
         st_nxt.pins.oe = 3'h0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r.state <= CCB_IDLE;
         st_r.code <= CCB_ST_PASSIVE;
         st_r.active <= 1'b0;
         st_r.max_mode <= 1'b0;
         st_r.strap_taken <= 1'b0;
         st_r.rst_prev <= 1'b0;
         st_r.nmi_prev <= 1'b0;
         st_r.nmi_pending <= 1'b0;
         st_r.nmi_take <= 1'b0;
         st_r.core_hold <= 1'b1;
         st_r.core_restart <= 1'b0;
         st_r.req_ready <= 1'b0;
         st_r.cycle_start <= 1'b0;
         st_r.cycle_end <= 1'b0;
         st_r.pins.value <= CCB_ST_PASSIVE;
         st_r.pins.oe <= 3'h0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic [7:0] type_r;
   logic [CCB_VEC_ADDR_W-1:0] vec_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         type_r <= CCB_EDGE_INT_TYPE;
         vec_r <= '0;
      end else begin
         type_r <= CCB_EDGE_INT_TYPE;
         vec_r <= ccb_vector_addr(CCB_EDGE_INT_TYPE);
      end
   end

   assign req_ready = st_r.req_ready;
   assign nmi_take = st_r.nmi_take;
   assign nmi_type = type_r;
   assign nmi_vector = vec_r;
   assign core_hold_reset = st_r.core_hold;
   assign core_restart = st_r.core_restart;
   assign status_pins = st_r.pins;
   assign clock_state = st_r.state;
   assign cycle_start = st_r.cycle_start;
   assign cycle_end = st_r.cycle_end;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_nmi_edge_take: assert property (@(posedge clk) disable iff (!resetn || rst_s)
      (nmi_s && !st_r.nmi_prev && !nmi_take) ##1 (!rst_s && instr_done) |=> nmi_take)
      else $error("edge interrupt not taken at instruction end");
   a_nmi_vector_val: assert property (@(posedge clk) disable iff (!resetn)
      nmi_take |-> (nmi_vector == 20'h00008) && (nmi_type == 8'h02))
      else $error("wrong vector for edge interrupt");
   a_nmi_needs_done: assert property (@(posedge clk) disable iff (!resetn)
      $rose(nmi_take) |-> $past(instr_done))
      else $error("edge interrupt taken mid-instruction");
   a_nmi_sync_delay: assert property (@(posedge clk) disable iff (!resetn)
      (!st_r.nmi_pending && !rst_s && !nmi_pin) ##1 (nmi_pin && !rst_s) |=> !st_r.nmi_pending)
      else $error("edge interrupt bypassed synchroniser");
   a_reset_abort: assert property (@(posedge clk) disable iff (!resetn)
      rst_s |=> (clock_state == CCB_IDLE) && (status_pins.value == 3'h7) && core_hold_reset)
      else $error("reset did not abort activity");
   a_restart_pulse: assert property (@(posedge clk) disable iff (!resetn)
      $fell(rst_s) |=> core_restart ##1 !core_restart)
      else $error("no restart pulse on reset release");
   a_status_passive: assert property (@(posedge clk) disable iff (!resetn)
      (clock_state == CCB_CLOCK_STATE_3 || clock_state == CCB_WAIT_STATE) |->
      status_pins.value == 3'h7)
      else $error("status not passive in state 3 or wait");
   a_status_active: assert property (@(posedge clk) disable iff (!resetn)
      cycle_start |-> (clock_state == CCB_CLOCK_STATE_4) && (status_pins.value != 3'h7 ||
      st_r.code == 3'h7) ##1 (clock_state == CCB_CLOCK_STATE_1) ##1
      (clock_state == CCB_CLOCK_STATE_2))
      else $error("bus cycle start sequence broken");
   a_cycle_end: assert property (@(posedge clk) disable iff (!resetn)
      (clock_state == CCB_CLOCK_STATE_2 && !rst_s) |=>
      cycle_end && clock_state == CCB_CLOCK_STATE_3)
      else $error("bus cycle end not marked in state 3");
   a_float_grant: assert property (@(posedge clk) disable iff (!resetn)
      bus_granted |=> status_pins.oe == 3'h0)
      else $error("status driven while bus granted");
   a_mode_strap: assert property (@(posedge clk) disable iff (!resetn)
      (status_pins.oe != 3'h0) |-> st_r.max_mode)
      else $error("status driven in minimum mode");

   // ----------------------------------------------------------------
   // reset checks
   // ----------------------------------------------------------------
   a_reset_sync_delay: assert property (@(posedge clk) disable iff (!resetn)
      !reset_pin [*3] ##1 reset_pin |=> !core_hold_reset)
      else $error("reset pin acted before synchronisation");
   a_reset_quiet: assert property (@(posedge clk) disable iff (!resetn)
      rst_s |=> !req_ready && !cycle_start && !cycle_end)
      else $error("bus activity while reset held");
   a_reset_nmi_clear: assert property (@(posedge clk) disable iff (!resetn)
      rst_s |=> !st_r.nmi_pending && !nmi_take)
      else $error("edge interrupt survived reset");
   a_restart_free: assert property (@(posedge clk) disable iff (!resetn)
      core_restart |-> !core_hold_reset)
      else $error("restart while core still held");

   // ----------------------------------------------------------------
   // bus status checks
   // ----------------------------------------------------------------
   a_code_follows: assert property (@(posedge clk) disable iff (!resetn)
      cycle_start |-> status_pins.value == $past(req_code))
      else $error("status code differs from request");
   a_code_held: assert property (@(posedge clk) disable iff (!resetn)
      (clock_state == CCB_CLOCK_STATE_1 || clock_state == CCB_CLOCK_STATE_2) |->
      $stable(status_pins.value))
      else $error("status code changed inside the cycle");
   a_wait_holds: assert property (@(posedge clk) disable iff (!resetn)
      ((clock_state == CCB_CLOCK_STATE_3 || clock_state == CCB_WAIT_STATE) && !ready &&
      !rst_s) |=> clock_state == CCB_WAIT_STATE)
      else $error("wait state left without ready");
   a_start_pulse: assert property (@(posedge clk) disable iff (!resetn)
      cycle_start |=> !cycle_start)
      else $error("cycle start longer than one cycle");
   a_end_passive: assert property (@(posedge clk) disable iff (!resetn)
      cycle_end |-> clock_state == CCB_CLOCK_STATE_3 && status_pins.value == 3'h7)
      else $error("cycle end without passive status");
   a_drive_free: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.max_mode && st_r.strap_taken && !bus_granted) |=> status_pins.oe == 3'h7)
      else $error("status not driven in maximum mode");

   c_nmi_taken: cover property (@(posedge clk) disable iff (!resetn) nmi_take);
   c_wait_cycle: cover property (@(posedge clk) disable iff (!resetn)
      clock_state == CCB_WAIT_STATE ##1 clock_state == CCB_CLOCK_STATE_4);
   c_back_to_back: cover property (@(posedge clk) disable iff (!resetn)
      cycle_end ##[1:20] cycle_start);
   c_restart: cover property (@(posedge clk) disable iff (!resetn) core_restart);
   c_reset_mid_cycle: cover property (@(posedge clk) disable iff (!resetn)
      rst_s && clock_state == CCB_CLOCK_STATE_2);

endmodule : ccb_core

// ===== ccb_bus_ctl_model.sv
// model of the external bus controller that decodes the status lines
`timescale 1ns/1ps
module ccb_bus_ctl_model (
   input wire logic clk,
   input wire logic resetn,
   input wire ccb_pkg::ccb_status_pins_t status_pins,
   input wire logic [1:0] wait_cycles,
   output logic ready,
   output logic [2:0] bus_level,
   output logic [2:0] cmd
);
   import ccb_pkg::*;
   logic [2:0] prev_r;
   logic [2:0] wcnt_r;
   // --------------------
   // line level and decode
   // --------------------
   // released lines are pulled up to one
   assign bus_level = (status_pins.value & status_pins.oe) | ~status_pins.oe;
   assign ready = (wcnt_r == 3'h0);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prev_r <= CCB_ST_PASSIVE;
         wcnt_r <= 3'h0;
         cmd <= CCB_ST_PASSIVE;
      end else begin
         prev_r <= bus_level;
         if (wcnt_r != 3'h0) wcnt_r <= wcnt_r - 3'h1;
         // leaving passive opens a cycle and latches its command
         if (prev_r == CCB_ST_PASSIVE && bus_level != CCB_ST_PASSIVE) begin
            cmd <= bus_level;
            wcnt_r <= {1'b0, wait_cycles} + 3'h2;
         end
         // return to passive closes the cycle
         if (prev_r != CCB_ST_PASSIVE && bus_level == CCB_ST_PASSIVE) cmd <= CCB_ST_PASSIVE;
      end
   end
endmodule : ccb_bus_ctl_model

// ===== ccb_core_tb_top.sv
// testbench of the control-input and bus-status block
`timescale 1ns/1ps
module ccb_core_tb_top;
   import ccb_pkg::*;
   logic clk, resetn, reset_pin, nmi_pin, bus_mode_strap, ready, bus_granted;
   logic req_valid, instr_done, req_ready, nmi_take, core_hold_reset, core_restart;
   logic cycle_start, cycle_end;
   logic [2:0] req_code, bus_level, cmd;
   logic [1:0] wait_cycles;
   logic [7:0] nmi_type;
   logic [CCB_VEC_ADDR_W-1:0] nmi_vector;
   ccb_status_pins_t status_pins;
   ccb_clk_state_t clock_state;
   int n_fail = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [7:0] lfsr = 8'h2F;
   logic [2:0] exp_q[$];
   ccb_core u_ccb_core (.clk(clk), .resetn(resetn), .reset_pin(reset_pin), .nmi_pin(nmi_pin),
      .bus_mode_strap(bus_mode_strap), .ready(ready), .bus_granted(bus_granted),
      .req_valid(req_valid), .req_code(req_code), .instr_done(instr_done),
      .req_ready(req_ready), .nmi_take(nmi_take), .nmi_type(nmi_type),
      .nmi_vector(nmi_vector), .core_hold_reset(core_hold_reset),
      .core_restart(core_restart), .status_pins(status_pins), .clock_state(clock_state),
      .cycle_start(cycle_start), .cycle_end(cycle_end));
   ccb_bus_ctl_model u_ccb_bus_ctl_model (.clk(clk), .resetn(resetn),
      .status_pins(status_pins), .wait_cycles(wait_cycles), .ready(ready),
      .bus_level(bus_level), .cmd(cmd));
   // --------------------
   // helpers
   // --------------------
   initial begin
      clk = 1'b0;
      forever begin
         #5.36 clk = ~clk;
         #2.64 clk = ~clk;
      end
   end
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   // one whole bus cycle with w wait states, checked against the model queue
   task automatic bus_cycle(input logic [2:0] code, input logic [1:0] w, input logic oe_exp);
      int n;
      n = 0;
      wait_cycles = w;
      if (oe_exp) exp_q.push_back(code);
      req_valid = 1'b1;
      req_code = code;
      while (req_ready !== 1'b1 && n < 50) begin
         step(1);
         n++;
      end
      step(1);
      req_valid = 1'b0;
      chk({clock_state, cycle_start, req_ready}, {CCB_CLOCK_STATE_4, 1'b1, 1'b0});
      chk(status_pins.oe, {3{oe_exp}});
      chk(bus_level, oe_exp ? code : CCB_ST_PASSIVE);
      step(2);
      chk({status_pins.value, bus_level}, {code, oe_exp ? code : CCB_ST_PASSIVE});
      chk(cmd, oe_exp ? exp_q.pop_front() : CCB_ST_PASSIVE);
      step(1);
      chk({clock_state, cycle_end, req_ready}, {CCB_CLOCK_STATE_3, 1'b1, 1'b1});
      n = 0;
      while ((clock_state == CCB_CLOCK_STATE_3 || clock_state == CCB_WAIT_STATE) && n < 20) begin
         chk(bus_level, CCB_ST_PASSIVE);
         step(1);
         n++;
      end
      chk(n, w + 1);
      step(1);
   endtask : bus_cycle
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         report_and_stop();
      end
   end
   // --------------------
   // main sequence
   // --------------------
   initial begin
      resetn = 1'b0;
      reset_pin = 1'b0;
      nmi_pin = 1'b0;
      bus_mode_strap = CCB_STRAP_MAX_MODE;
      bus_granted = 1'b0;
      req_valid = 1'b0;
      req_code = 3'h0;
      instr_done = 1'b0;
      wait_cycles = 2'h0;
      repeat (6) @(posedge clk);
      #1 resetn = 1'b1;
      step(2);
      for (int i = 0; i < 12; i++) begin
         lfsr = lfsr_next(lfsr);
         bus_cycle((i < 7) ? i[2:0] : ((lfsr[6:4] == 3'h7) ? 3'h5 : lfsr[6:4]),
            (lfsr[1:0] == 2'h3) ? 2'h0 : lfsr[1:0], 1'b1);
      end
      // granted bus: floated lines, request held off
      bus_granted = 1'b1;
      req_valid = 1'b1;
      req_code = CCB_ST_MEM_RD;
      step(3);
      chk({status_pins.oe, bus_level, clock_state}, {3'h0, CCB_ST_PASSIVE, CCB_IDLE});
      bus_granted = 1'b0;
      req_valid = 1'b0;
      step(1);
      bus_cycle(CCB_ST_MEM_RD, 2'h1, 1'b1);
      // edge interrupt waits for instruction end
      nmi_pin = 1'b1;
      for (int i = 0; i < 6; i++) begin
         step(1);
         chk(nmi_take, 1'b0);
      end
      instr_done = 1'b1;
      step(1);
      instr_done = 1'b0;
      chk({nmi_take, nmi_type}, {1'b1, 8'h02});
      chk(nmi_vector, {12'h0, CCB_EDGE_INT_TYPE} << CCB_VEC_SHIFT);
      step(1);
      chk(nmi_take, 1'b0);
      // edge arriving while instruction end is already signalled
      nmi_pin = 1'b0;
      step(3);
      instr_done = 1'b1;
      nmi_pin = 1'b1;
      step(3);
      chk(nmi_take, 1'b0);
      step(1);
      chk(nmi_take, 1'b1);
      instr_done = 1'b0;
      step(1);
      // reset pin in mid cycle
      req_code = CCB_ST_MEM_WR;
      req_valid = 1'b1;
      step(1);
      req_valid = 1'b0;
      reset_pin = 1'b1;
      step(2);
      chk({core_hold_reset, clock_state}, {1'b0, CCB_CLOCK_STATE_2});
      step(1);
      chk({core_hold_reset, clock_state, bus_level, cycle_end},
         {1'b1, CCB_IDLE, CCB_ST_PASSIVE, 1'b0});
      step(1);
      reset_pin = 1'b0;
      for (int i = 1; i <= 4; i++) begin
         step(1);
         chk({core_restart, core_hold_reset}, {i == 3, i < 3});
      end
      // minimum mode keeps status lines released
      resetn = 1'b0;
      bus_mode_strap = 1'b1;
      step(2);
      resetn = 1'b1;
      step(2);
      bus_cycle(CCB_ST_IO_WR, 2'h0, 1'b0);
      report_and_stop();
   end
endmodule : ccb_core_tb_top
